// >>> pkg/t1lam_pkg.sv
/*
 Constants shared by the T1 line alarm monitor: condition positions, detector limits,
 register map, self-test figures and the self-test state type.
 Assumes a single 250 MHz device clock and a 32-bit AHB-Lite register bus.
*/
// Operation
// - Declare loss of signal after 175 consecutive received zeros on an interface.
// - Clear loss of signal once received ones density reaches 12.5 percent.
// - Declare network out of frame when 2 of 4 framing bits err.
// - Hold out of frame until the framer reframes, on both interfaces.
// - Flag AIS while an unframed all-ones stream is received.
// - Assert excessive error rate when ESF error rate exceeds the set threshold.
// - Deassert excessive error rate once the error rate falls below the threshold.
// - Flag yellow alarm on each interface while yellow is being received.
// - Rank conditions from network LOS down to DTE yellow in fixed order.
// - Sample the condition set every ten seconds.
// - Update reported status and top condition only when the sample changed.
// - Enter summary view after five minutes without key activity.
// - Self-test checks program memory checksum and reports memory failure.
// - Self-test checks encoder and LOS detector, reporting one combined failure.
// - Self-test checks AIS transmit and yellow detection, reporting alarm failure.
// - Self-test loops data through the network circuit and reports mismatch.
// - Self-test loops data through the DTE circuit and reports distinct failure.
// - Unclassified self-test failure provides an 8 hex digit failure code.
// - Report operational only when no alarm or status condition is active.
package t1lam_pkg;
	localparam int unsigned IF_NET = 0;
	localparam int unsigned IF_DTE = 1;

	localparam logic [7:0]  LOS_ZEROS     = 8'haf;
	localparam logic [7:0]  DENS_WIN      = 8'hc0;
	localparam int unsigned DENS_PERMILLE = 125;
	localparam logic [7:0]  DENS_ONES_MIN = 8'(int'(DENS_WIN) * DENS_PERMILLE / 1000);
	localparam logic [2:0]  FS_ERR_MAX    = 3'h2;
	localparam logic [11:0] AIS_ONES      = 12'h800;
	localparam logic [15:0] EER_WIN       = 16'h1f40;
	localparam logic [15:0] EER_THR_RST   = 16'h000a;

	localparam longint unsigned CLK_HZ   = 250000000;
	localparam longint unsigned SAMPLE_S = 10;
	localparam longint unsigned IDLE_MIN = 5;

	localparam int unsigned NCOND     = 9;
	localparam int unsigned C_NET_LOS = 0;
	localparam int unsigned C_DTE_LOS = 1;
	localparam int unsigned C_NET_OOF = 2;
	localparam int unsigned C_DTE_OOF = 3;
	localparam int unsigned C_NET_AIS = 4;
	localparam int unsigned C_DTE_AIS = 5;
	localparam int unsigned C_NET_EER = 6;
	localparam int unsigned C_NET_YEL = 7;
	localparam int unsigned C_DTE_YEL = 8;

	localparam logic [7:0] REG_CTRL  = 8'h00;
	localparam logic [7:0] REG_THR   = 8'h04;
	localparam logic [7:0] REG_COND  = 8'h08;
	localparam logic [7:0] REG_RPT   = 8'h0c;
	localparam logic [7:0] REG_STEST = 8'h10;
	localparam logic [7:0] REG_CODE  = 8'h14;
	localparam int unsigned CTRL_ESF = 0;
	localparam int unsigned CTRL_RUN = 1;
	localparam int unsigned RPT_TOP  = 16;
	localparam int unsigned RPT_AUTO = 24;
	localparam int unsigned RPT_OPER = 25;
	localparam int unsigned STB_DONE = 8;
	localparam int unsigned STB_PASS = 9;

	localparam int unsigned NFAIL  = 6;
	localparam int unsigned F_MEM  = 0;
	localparam int unsigned F_ENC  = 1;
	localparam int unsigned F_ALM  = 2;
	localparam int unsigned F_NET  = 3;
	localparam int unsigned F_DTE  = 4;
	localparam int unsigned F_DEV  = 5;

	localparam logic [15:0] PM_WORDS   = 16'h0100;
	localparam logic [15:0] LOOP_LEN   = 16'h0040;
	localparam logic [15:0] LOS_LEN    = 16'h00b4;
	localparam logic [15:0] ALM_LEN    = 16'h03e8;
	localparam logic [6:0]  LFSR_SEED  = 7'h7f;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_MEM  = 3'h1,
		ST_ENC  = 3'h3,
		ST_LOS  = 3'h2,
		ST_ALM  = 3'h6,
		ST_NET  = 3'h7,
		ST_DTE  = 3'h5,
		ST_DONE = 3'h4
	} t1lam_st_t;
endpackage

// >>> verilog/t1lam_line_det.sv
/*
 Loss of signal and AIS detector for one receive stream.
 Assumes received bits arrive from framer logic on hclk with a one-cycle valid strobe.
*/
`timescale 1ns/100ps
`default_nettype none
module t1lam_line_det import t1lam_pkg::*; (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic ce,
	input  wire logic bit_vld,
	input  wire logic bit_val,
	input  wire logic oof,
	output logic      los,
	output logic      ais
);
	logic [7:0]  zcnt_q;
	logic [7:0]  win_q;
	logic [7:0]  ones_q;
	logic [11:0] run_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			zcnt_q <= 8'h00;
		end else if (ce && bit_vld) begin
			if (bit_val)
				zcnt_q <= 8'h00;
			else if (zcnt_q != LOS_ZEROS)
				zcnt_q <= zcnt_q + 8'h01;
		end
	end

	// Density is judged over fixed windows, so clearing lags recovery by up to two windows.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			win_q  <= 8'h00;
			ones_q <= 8'h00;
			los    <= 1'b0;
		end else if (ce && bit_vld) begin
			if (win_q == DENS_WIN - 8'h01) begin
				win_q  <= 8'h00;
				ones_q <= 8'h00;
			end else begin
				win_q  <= win_q + 8'h01;
				ones_q <= ones_q + {7'h00, bit_val};
			end
			if (!bit_val && zcnt_q == LOS_ZEROS - 8'h01)
				los <= 1'b1;
			else if (win_q == DENS_WIN - 8'h01 && ones_q + {7'h00, bit_val} >= DENS_ONES_MIN)
				los <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_q <= 12'h000;
			ais   <= 1'b0;
		end else if (ce && bit_vld) begin
			if (!bit_val || !oof) begin
				run_q <= 12'h000;
				ais   <= 1'b0;
			end else if (run_q != AIS_ONES) begin
				run_q <= run_q + 12'h001;
			end else begin
				ais <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> verilog/t1lam_oof_det.sv
/*
 Out-of-frame detector for one interface: watches the last four framing bits.
 Assumes the framer gives a strobe per framing bit with its error flag and a reframe pulse.
*/
`timescale 1ns/100ps
`default_nettype none
module t1lam_oof_det import t1lam_pkg::*; (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic ce,
	input  wire logic fs_vld,
	input  wire logic fs_err,
	input  wire logic reframe,
	output logic      oof
);
	logic [3:0] hist_q;
	logic [3:0] hist_d;
	logic [2:0] nerr;
	logic       hit;

	assign hist_d = {hist_q[2:0], fs_err};
	assign nerr   = 3'({2'h0, hist_d[0]} + {2'h0, hist_d[1]} + {2'h0, hist_d[2]} + {2'h0, hist_d[3]});
	assign hit    = fs_vld && nerr >= FS_ERR_MAX;

	// A declaration in the reframe cycle wins, so a fresh loss of framing is never lost.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hist_q <= 4'h0;
			oof    <= 1'b0;
		end else if (ce) begin
			if (hit)
				oof <= 1'b1;
			else if (reframe)
				oof <= 1'b0;
			if (fs_vld)
				hist_q <= hist_d;
			else if (reframe)
				hist_q <= 4'h0;
		end
	end
endmodule
`default_nettype wire

// >>> verilog/t1lam_top.sv
/*
 T1 line alarm monitor: per-interface LOS, OOF, AIS and yellow detection, network EER,
 priority ranking, ten-second status sampling, inactivity summary view and power-up self-test,
 with registers on AHB-Lite.
 Assumes framers, looped circuits and program memory run on hclk; only the key pin is asynchronous.
*/
`timescale 1ns/100ps
`default_nettype none
module t1lam_top import t1lam_pkg::*; #(
	parameter logic [39:0] SAMPLE_CYC = 40'(SAMPLE_S * CLK_HZ),
	parameter logic [39:0] IDLE_CYC   = 40'(IDLE_MIN * 60 * CLK_HZ)
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic [1:0]  rx_vld,
	input  wire logic [1:0]  rx_bit,
	input  wire logic [1:0]  fs_vld,
	input  wire logic [1:0]  fs_err,
	input  wire logic [1:0]  reframe,
	input  wire logic [1:0]  yel_rx,
	input  wire logic        crc_err,
	input  wire logic        key_press,
	output logic [7:0]       pm_addr,
	input  wire logic [15:0] pm_data,
	input  wire logic [15:0] pm_sum_ref,
	output logic [2:0]       st_mode,
	output logic             st_tx_bit,
	input  wire logic        st_rx_bit,
	output logic             ais_tx,
	input  wire logic        dev_fault,
	output logic [8:0]       cond,
	output logic [8:0]       rpt_cond,
	output logic [3:0]       rpt_top,
	output logic             auto_view,
	output logic             operational,
	output logic             st_busy
);
	logic [1:0]       los;
	logic [1:0]       ais;
	logic [1:0]       oof;
	logic [1:0]       det_vld;
	logic [1:0]       det_bit;
	logic [1:0]       yel_q;
	logic             eer_q;
	logic [15:0]      eer_win_q;
	logic [15:0]      eer_cnt_q;
	logic [15:0]      thr_q;
	logic             esf_q;
	logic             wr_pend_q;
	logic [7:0]       wr_addr_q;
	logic [31:0]      rd_d;
	logic             go_q;
	logic             run_wr;
	t1lam_st_t        st_q;
	logic [15:0]      cnt_q;
	logic [15:0]      sum_q;
	logic [15:0]      sum_nx;
	logic [6:0]       lfsr_q;
	logic             prev_tx_q;
	logic             yel_seen_q;
	logic [NFAIL-1:0] fail_q;
	logic             done_q;
	logic [31:0]      code_q;
	logic             loop_st;
	logic             last;
	logic [8:0]       smp_q;
	logic [39:0]      smp_cnt_q;
	logic [39:0]      idle_cnt_q;
	logic             key_s1_q;
	logic             key_s2_q;
	logic             key_s3_q;
	logic             key_ev;
	logic [3:0]       top_d;

	// Bus slave: zero wait states while running; the whole block, bus included, stalls with ce.
	assign hreadyout = ce;
	assign hresp     = 1'b0;
	assign run_wr    = wr_pend_q && wr_addr_q == REG_CTRL && hwdata[CTRL_RUN];

	always_comb begin
		rd_d = 32'h0000_0000;
		if (haddr[7:0] == REG_CTRL) begin
			rd_d[CTRL_ESF] = esf_q;
			rd_d[CTRL_RUN] = go_q;
		end else if (haddr[7:0] == REG_THR) begin
			rd_d[15:0] = thr_q;
		end else if (haddr[7:0] == REG_COND) begin
			rd_d[8:0] = cond;
		end else if (haddr[7:0] == REG_RPT) begin
			rd_d[8:0]              = rpt_cond;
			rd_d[RPT_TOP+3:RPT_TOP] = rpt_top;
			rd_d[RPT_AUTO]         = auto_view;
			rd_d[RPT_OPER]         = operational;
		end else if (haddr[7:0] == REG_STEST) begin
			rd_d[NFAIL-1:0] = fail_q;
			rd_d[STB_DONE]  = done_q;
			rd_d[STB_PASS]  = done_q && fail_q == '0;
		end else if (haddr[7:0] == REG_CODE) begin
			rd_d = code_q;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hrdata    <= 32'h0000_0000;
		end else if (ce) begin
			wr_pend_q <= hsel && hready && htrans[1] && hwrite && hsize == 3'h2;
			wr_addr_q <= haddr[7:0];
			if (hsel && hready && htrans[1] && !hwrite)
				hrdata <= rd_d;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			esf_q <= 1'b0;
			thr_q <= EER_THR_RST;
		end else if (ce && wr_pend_q) begin
			if (wr_addr_q == REG_CTRL)
				esf_q <= hwdata[CTRL_ESF];
			else if (wr_addr_q == REG_THR)
				thr_q <= hwdata[15:0];
		end
	end

	// Per-interface detectors; the network LOS detector is fed zeros during its self-test step.
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_if
			assign det_vld[gi] = (gi == IF_NET && st_q == ST_LOS) ? 1'b1 : rx_vld[gi];
			assign det_bit[gi] = (gi == IF_NET && st_q == ST_LOS) ? 1'b0 : rx_bit[gi];
			t1lam_line_det u_line (
				.hclk    (hclk),
				.hresetn (hresetn),
				.ce      (ce),
				.bit_vld (det_vld[gi]),
				.bit_val (det_bit[gi]),
				.oof     (oof[gi]),
				.los     (los[gi]),
				.ais     (ais[gi])
			);
			t1lam_oof_det u_oof (
				.hclk    (hclk),
				.hresetn (hresetn),
				.ce      (ce),
				.fs_vld  (fs_vld[gi]),
				.fs_err  (fs_err[gi]),
				.reframe (reframe[gi]),
				.oof     (oof[gi])
			);
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			yel_q <= 2'h0;
		else if (ce)
			yel_q <= yel_rx;
	end

	// Errors are counted over a fixed number of received network bits.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			eer_win_q <= 16'h0000;
			eer_cnt_q <= 16'h0000;
			eer_q     <= 1'b0;
		end else if (ce) begin
			if (!esf_q) begin
				eer_win_q <= 16'h0000;
				eer_cnt_q <= 16'h0000;
				eer_q     <= 1'b0;
			end else if (rx_vld[IF_NET] && eer_win_q == EER_WIN - 16'h0001) begin
				eer_win_q <= 16'h0000;
				eer_cnt_q <= 16'h0000;
				if (eer_cnt_q > thr_q)
					eer_q <= 1'b1;
				else if (eer_cnt_q < thr_q)
					eer_q <= 1'b0;
			end else begin
				if (rx_vld[IF_NET])
					eer_win_q <= eer_win_q + 16'h0001;
				if (crc_err && eer_cnt_q != 16'hffff)
					eer_cnt_q <= eer_cnt_q + 16'h0001;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cond <= 9'h000;
		end else if (ce) begin
			cond[C_NET_LOS] <= los[IF_NET];
			cond[C_DTE_LOS] <= los[IF_DTE];
			cond[C_NET_OOF] <= oof[IF_NET];
			cond[C_DTE_OOF] <= oof[IF_DTE];
			cond[C_NET_AIS] <= ais[IF_NET];
			cond[C_DTE_AIS] <= ais[IF_DTE];
			cond[C_NET_EER] <= eer_q;
			cond[C_NET_YEL] <= yel_q[IF_NET];
			cond[C_DTE_YEL] <= yel_q[IF_DTE];
		end
	end

	// Lowest bit index is highest priority; code 0 means nothing active.
	always_comb begin
		top_d = 4'h0;
		for (int i = NCOND - 1; i >= 0; i--) begin
			if (cond[i])
				top_d = 4'(i + 1);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			smp_cnt_q <= 40'h00_0000_0000;
			smp_q     <= 9'h000;
			rpt_cond  <= 9'h000;
			rpt_top   <= 4'h0;
		end else if (ce) begin
			if (smp_cnt_q == SAMPLE_CYC - 40'h00_0000_0001) begin
				smp_cnt_q <= 40'h00_0000_0000;
				smp_q     <= cond;
				if (cond != smp_q) begin
					rpt_cond <= cond;
					rpt_top  <= top_d;
				end
			end else begin
				smp_cnt_q <= smp_cnt_q + 40'h00_0000_0001;
			end
		end
	end

	assign key_ev = key_s2_q && !key_s3_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			key_s1_q   <= 1'b0;
			key_s2_q   <= 1'b0;
			key_s3_q   <= 1'b0;
			idle_cnt_q <= 40'h00_0000_0000;
			auto_view  <= 1'b0;
		end else if (ce) begin
			key_s1_q <= key_press;
			key_s2_q <= key_s1_q;
			key_s3_q <= key_s2_q;
			if (key_ev) begin
				idle_cnt_q <= 40'h00_0000_0000;
				auto_view  <= 1'b0;
			end else if (idle_cnt_q == IDLE_CYC - 40'h00_0000_0001) begin
				auto_view <= 1'b1;
			end else begin
				idle_cnt_q <= idle_cnt_q + 40'h00_0000_0001;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			operational <= 1'b0;
		else if (ce)
			operational <= cond == 9'h000 && done_q && fail_q == '0;
	end

	// Self-test runs once after reset and again on each software request.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			go_q <= 1'b1;
		else if (ce)
			go_q <= run_wr || (go_q && st_q != ST_IDLE);
	end

	assign loop_st = st_q == ST_ENC || st_q == ST_NET || st_q == ST_DTE;
	assign sum_nx  = sum_q + pm_data;
	assign pm_addr = cnt_q[7:0];
	assign st_busy = st_q != ST_IDLE;
	assign ais_tx  = st_q == ST_ALM;
	assign st_mode = st_q;
	assign last    = (st_q == ST_MEM && cnt_q == PM_WORDS - 16'h0001)
		|| (loop_st && cnt_q == LOOP_LEN - 16'h0001)
		|| (st_q == ST_LOS && cnt_q == LOS_LEN - 16'h0001)
		|| (st_q == ST_ALM && cnt_q == ALM_LEN - 16'h0001);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q  <= ST_IDLE;
			cnt_q <= 16'h0000;
			sum_q <= 16'h0000;
		end else if (ce) begin
			cnt_q <= last || st_q == ST_IDLE ? 16'h0000 : cnt_q + 16'h0001;
			sum_q <= st_q == ST_MEM ? sum_nx : 16'h0000;
			case (st_q)
				ST_IDLE: if (go_q) st_q <= ST_MEM;
				ST_MEM:  if (last) st_q <= ST_ENC;
				ST_ENC:  if (last) st_q <= ST_LOS;
				ST_LOS:  if (last) st_q <= ST_ALM;
				ST_ALM:  if (last) st_q <= ST_NET;
				ST_NET:  if (last) st_q <= ST_DTE;
				ST_DTE:  if (last) st_q <= ST_DONE;
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// The looped circuits return each transmitted bit one cycle later.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lfsr_q     <= LFSR_SEED;
			st_tx_bit  <= 1'b0;
			prev_tx_q  <= 1'b0;
			yel_seen_q <= 1'b0;
		end else if (ce) begin
			lfsr_q     <= loop_st ? {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[5]} : LFSR_SEED;
			st_tx_bit  <= loop_st && lfsr_q[0];
			prev_tx_q  <= st_tx_bit;
			yel_seen_q <= st_q == ST_ALM && (yel_seen_q || yel_q[IF_NET]);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fail_q <= '0;
			done_q <= 1'b0;
			code_q <= 32'h0000_0000;
		end else if (ce) begin
			if (st_q == ST_IDLE && go_q) begin
				fail_q <= '0;
				done_q <= 1'b0;
				code_q <= 32'h0000_0000;
			end
			if (st_q == ST_MEM && last && sum_nx != pm_sum_ref)
				fail_q[F_MEM] <= 1'b1;
			if (st_q == ST_ENC && cnt_q > 16'h0001 && st_rx_bit != prev_tx_q)
				fail_q[F_ENC] <= 1'b1;
			if (st_q == ST_LOS && last && !los[IF_NET])
				fail_q[F_ENC] <= 1'b1;
			if (st_q == ST_ALM && last && !yel_seen_q)
				fail_q[F_ALM] <= 1'b1;
			if (st_q == ST_NET && cnt_q > 16'h0001 && st_rx_bit != prev_tx_q)
				fail_q[F_NET] <= 1'b1;
			if (st_q == ST_DTE && cnt_q > 16'h0001 && st_rx_bit != prev_tx_q)
				fail_q[F_DTE] <= 1'b1;
			if (st_busy && st_q != ST_DONE && dev_fault && !fail_q[F_DEV]) begin
				fail_q[F_DEV] <= 1'b1;
				code_q        <= {13'h0000, st_q, cnt_q};
			end
			if (st_q == ST_DONE)
				done_q <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// >>> tb/t1lam_properties.sv
/*
 Checker for the T1 line alarm monitor top, bound to every instance of it.
 Assumes one clock, hclk, with hresetn as its asynchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module t1lam_checker import t1lam_pkg::*; #(
	parameter logic [39:0] SAMPLE_CYC = 40'h64,
	parameter logic [39:0] IDLE_CYC   = 40'h12c
) (
	input wire logic       hclk,
	input wire logic       hresetn,
	input wire logic       ce,
	input wire logic       hreadyout,
	input wire logic       hresp,
	input wire logic       key_press,
	input wire logic       auto_view,
	input wire logic       operational,
	input wire logic       st_busy,
	input wire logic [1:0] rx_vld,
	input wire logic [1:0] rx_bit,
	input wire logic [1:0] fs_vld,
	input wire logic [1:0] fs_err,
	input wire logic [1:0] reframe,
	input wire logic [1:0] yel_rx,
	input wire logic [8:0] cond,
	input wire logic [8:0] rpt_cond,
	input wire logic [3:0] rpt_top
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic [7:0] zrun_q;
	logic [3:0] fsh_q;
	// Own count of network zeros, so the detector is judged against the line and not itself.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			zrun_q <= 8'h0;
		end else if (ce && rx_vld[0]) begin
			zrun_q <= rx_bit[0] ? 8'h0 : zrun_q + {7'h0, zrun_q != 8'hff};
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fsh_q <= 4'h0;
		end else if (ce && fs_vld[0]) begin
			fsh_q <= {fsh_q[2:0], fs_err[0]};
		end
	end
	AST_NET_LOS_RUN: assert property ($rose(cond[0]) && !st_busy && !$past(st_busy) |-> zrun_q >= LOS_ZEROS)
		else $error("network loss of signal without its zero run");
	AST_NET_OOF_SET: assert property ($rose(cond[2]) |-> $countones(fsh_q) >= 2)
		else $error("network out of frame with fewer than two framing errors");
	AST_NET_OOF_HOLD: assert property ($fell(cond[2]) |-> $past(reframe[0], 2))
		else $error("network out of frame cleared without reframe");
	AST_NET_AIS_OOF: assert property ($rose(cond[4]) |-> cond[2])
		else $error("network AIS on a framed stream");
	AST_NET_YEL: assert property (ce[*3] |-> cond[7] == $past(yel_rx[0], 2))
		else $error("network yellow does not follow the line");
	AST_DTE_YEL: assert property (ce[*3] |-> cond[8] == $past(yel_rx[1], 2))
		else $error("DTE yellow does not follow the line");
	AST_TOP_RANK: assert property (rpt_top == 4'h0 ? rpt_cond == 9'h0 : (rpt_cond[rpt_top - 4'h1]
		&& (rpt_cond & ((9'h1 << (rpt_top - 4'h1)) - 9'h1)) == 9'h0))
		else $error("top condition is not the highest ranked one");
	AST_OPER: assert property ((cond != 9'h0)[*3] |-> !operational)
		else $error("operational while a condition is active");
	AST_KEY_WAKE: assert property ($rose(key_press) |-> ##[1:5] !auto_view)
		else $error("summary view not left after a key press");
	AST_BUS_OKAY: assert property (hresp == 1'b0 && hreadyout == ce)
		else $error("bus response not OKAY or ready not following enable");
	COV_LOS: cover property ($rose(cond[0]));
	COV_EER: cover property ($rose(cond[6]));
	COV_AUTO: cover property ($rose(auto_view));
	COV_DONE: cover property ($fell(st_busy));
endmodule
bind t1lam_top t1lam_checker #(.SAMPLE_CYC(SAMPLE_CYC), .IDLE_CYC(IDLE_CYC)) chk_u (.hclk, .hresetn, .ce, .hreadyout,
	.hresp, .key_press, .auto_view, .operational, .st_busy, .rx_vld, .rx_bit, .fs_vld, .fs_err, .reframe, .yel_rx,
	.cond, .rpt_cond, .rpt_top);
`default_nettype wire

// >>> tb/t1lam_far_model.sv
/*
 Far-side model: program memory, looped return path and yellow return seen by the self-test.
 Assumes the testbench names one self-test step to spoil through bad_step.
*/
`timescale 1ns/100ps
`default_nettype none
module t1lam_far_model import t1lam_pkg::*; (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic [2:0]  bad_step,
	input  wire logic [1:0]  yel_in,
	input  wire logic [2:0]  st_mode,
	input  wire logic        st_tx_bit,
	input  wire logic        ais_tx,
	input  wire logic [7:0]  pm_addr,
	output logic [15:0]      pm_data,
	output logic [15:0]      pm_sum_ref,
	output logic             st_rx_bit,
	output logic [1:0]       yel_rx
);
	// Each word carries its address under a fixed byte, so the wrap sum of 256 words is 7f80.
	assign pm_data = {8'h5a, pm_addr};
	assign pm_sum_ref = (bad_step == ST_MEM) ? 16'h7f81 : 16'h7f80;
	// The return lags one cycle; in the spoiled step every bit comes back inverted.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_rx_bit <= 1'b0;
		end else begin
			st_rx_bit <= st_tx_bit ^ (st_mode == bad_step);
		end
	end
	assign yel_rx = {yel_in[1], yel_in[0] | (ais_tx && bad_step != ST_ALM)};
endmodule
`default_nettype wire

// >>> tb/t1_line_alarm_monitor_test.sv
/*
 Self-checking bench for the T1 line alarm monitor: self-test, detectors, status sampling, bus.
 Assumes the far-side model and the bound checker are compiled with it.
*/
`timescale 1ns/100ps
`default_nettype none
module t1_line_alarm_monitor_test;
	import t1lam_pkg::*;
	localparam int SMP = 100;
	localparam int IDL = 300;
	logic hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0, crc_err = 1'b0;
	logic key_press = 1'b0, dev_fault = 1'b0, hreadyout, hresp, st_tx_bit, st_rx_bit, ais_tx;
	logic auto_view, operational, st_busy;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0, rx_vld = 2'h0, rx_bit = 2'h0, fs_vld = 2'h0, fs_err = 2'h0;
	logic [1:0] reframe = 2'h0, yel_in = 2'h0, yel_rx;
	logic [2:0] hsize = 3'h2, bad = 3'h0, st_mode;
	logic [7:0] pm_addr;
	logic [15:0] pm_data, pm_sum_ref;
	logic [8:0] cond, rpt_cond, ec = 9'h0;
	logic [3:0] rpt_top;
	int n_errors = 0, total_checks = 0, cyc = 0, seed = 30562, zr[2] = '{0, 0};
	int fq[2][$];
	logic [2:0] modes[6] = '{ST_MEM, ST_ENC, ST_ALM, ST_NET, ST_DTE, ST_IDLE};
	int fb[6] = '{F_MEM, F_ENC, F_ALM, F_NET, F_DTE, -1};
	t1lam_top #(.SAMPLE_CYC(40'(SMP)), .IDLE_CYC(40'(IDL))) dut_u (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .rx_vld, .rx_bit, .fs_vld, .fs_err, .reframe,
		.yel_rx, .crc_err, .key_press, .pm_addr, .pm_data, .pm_sum_ref, .st_mode, .st_tx_bit, .st_rx_bit, .ais_tx,
		.dev_fault, .cond, .rpt_cond, .rpt_top, .auto_view, .operational, .st_busy);
	t1lam_far_model far_u (.hclk, .hresetn, .bad_step(bad), .yel_in, .st_mode, .st_tx_bit, .ais_tx, .pm_addr,
		.pm_data, .pm_sum_ref, .st_rx_bit, .yel_rx);
	initial forever #2 hclk = ~hclk;
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// A hung handshake or self-test ends here instead of running forever.
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 90000) begin
			n_errors++;
			give_verdict();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cchk();
		chk("cond", {23'h0, cond}, {23'h0, ec});
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	// Ones fall on every per-th bit; with per zero the stream is all zeros.
	task automatic bits(input int ifc, input int n, input int per, input int eper);
		for (int k = 0; k < n; k++) begin
			@(posedge hclk);
			rx_vld[ifc] <= 1'b1;
			rx_bit[ifc] <= per != 0 && k % per == per - 1;
			crc_err <= eper != 0 && k % eper == 0;
			zr[ifc] = (per != 0 && k % per == per - 1) ? 0 : zr[ifc] + 1;
			if (zr[ifc] >= 175) ec[ifc] = 1'b1;
		end
		@(posedge hclk);
		rx_vld[ifc] <= 1'b0;
		crc_err <= 1'b0;
		repeat (3) @(posedge hclk);
	endtask
	task automatic fs(input int ifc, input logic e);
		@(posedge hclk);
		fs_vld[ifc] <= 1'b1;
		fs_err[ifc] <= e;
		fq[ifc].push_back(int'(e));
		if (fq[ifc].size() > 4) void'(fq[ifc].pop_front());
		if (fq[ifc].sum() >= 2) ec[2 + ifc] = 1'b1;
		@(posedge hclk);
		fs_vld[ifc] <= 1'b0;
		repeat (3) @(posedge hclk);
	endtask
	task automatic rpt_chk();
		logic [31:0] rd;
		logic [3:0] top;
		top = 4'h0;
		for (int b = 8; b >= 0; b--) if (ec[b]) top = 4'(b + 1);
		repeat (2 * SMP + 5) @(posedge hclk);
		bus(1'b0, REG_RPT, 32'h0, rd);
		chk("rpt_cond", {23'h0, rd[8:0]}, {23'h0, ec});
		chk("rpt_top", {28'h0, rd[19:16]}, {28'h0, top});
	endtask
	task automatic st_run(input logic go, input logic [2:0] b, input logic df, input logic [9:0] exp);
		logic [31:0] rd;
		bad <= b;
		if (go) bus(1'b1, REG_CTRL, 32'h2, rd);
		wait (st_busy === 1'b1);
		@(posedge hclk);
		dev_fault <= df;
		@(posedge hclk);
		dev_fault <= 1'b0;
		wait (st_busy === 1'b0);
		repeat (4) @(posedge hclk);
		bus(1'b0, REG_STEST, 32'h0, rd);
		chk("stest", {22'h0, rd[9:0]}, {22'h0, exp});
	endtask
	initial begin
		logic [31:0] rd;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		st_run(1'b0, ST_IDLE, 1'b0, 10'h300);
		bus(1'b0, REG_THR, 32'h0, rd);
		chk("thr", rd, 32'ha);
		bus(1'b0, 8'h18, 32'h0, rd);
		chk("unmapped", rd, 32'h0);
		st_run(1'b1, ST_IDLE, 1'b1, 10'h120);
		bus(1'b0, REG_CODE, 32'h0, rd);
		chk("code", rd >> 16, 32'(ST_MEM));
		for (int i = 0; i < 6; i++) begin
			st_run(1'b1, modes[i], 1'b0, fb[i] < 0 ? 10'h300 : 10'h100 | 10'(1 << fb[i]));
		end
		for (int i = 0; i < 2; i++) begin
			bits(i, 400, 8, 0);
			ec[i] = 1'b0;
			cchk();
			chk("oper", {31'h0, operational}, 32'h1);
			bits(i, 174, 0, 0);
			cchk();
			bits(i, 1, 0, 0);
			cchk();
			chk("oper", {31'h0, operational}, 32'h0);
			rpt_chk();
			bits(i, 400, 8, 0);
			ec[i] = 1'b0;
			cchk();
		end
		for (int i = 0; i < 2; i++) begin
			fs(i, 1'b1);
			fs(i, 1'b0);
			fs(i, 1'b0);
			fs(i, 1'b0);
			fs(i, 1'b1);
			cchk();
			fs(i, 1'b1);
			cchk();
			bits(i, 2049, 1, 0);
			ec[4 + i] = 1'b1;
			cchk();
			rpt_chk();
			bits(i, 2, 2, 0);
			ec[4 + i] = 1'b0;
			cchk();
			reframe[i] <= 1'b1;
			@(posedge hclk);
			reframe[i] <= 1'b0;
			repeat (3) @(posedge hclk);
			ec[2 + i] = 1'b0;
			fq[i].delete();
			cchk();
		end
		for (int i = 0; i < 4; i++) begin
			yel_in <= 2'($random(seed));
			repeat (4) @(posedge hclk);
			ec[8:7] = yel_in;
			cchk();
			rpt_chk();
		end
		yel_in <= 2'h0;
		ec[8:7] = 2'h0;
		bus(1'b1, REG_THR, 32'h2, rd);
		bus(1'b0, REG_THR, 32'h0, rd);
		chk("thr", rd, 32'h2);
		bus(1'b1, REG_CTRL, 32'h1, rd);
		// Errors every 2000 bits put exactly four in any 8000-bit window, whatever its phase.
		bits(0, 16000, 1, 2000);
		ec[6] = 1'b1;
		cchk();
		bits(0, 16000, 1, 8000);
		ec[6] = 1'b0;
		cchk();
		repeat (IDL + 20) @(posedge hclk);
		chk("auto", {31'h0, auto_view}, 32'h1);
		key_press <= 1'b1;
		repeat (6) @(posedge hclk);
		chk("auto", {31'h0, auto_view}, 32'h0);
		key_press <= 1'b0;
		ce <= 1'b0;
		repeat (50) @(posedge hclk);
		ce <= 1'b1;
		repeat (IDL - 40) @(posedge hclk);
		chk("auto", {31'h0, auto_view}, 32'h0);
		repeat (60) @(posedge hclk);
		chk("auto", {31'h0, auto_view}, 32'h1);
		give_verdict();
	end
endmodule
`default_nettype wire
